// *** hdl/regulator_four_defines.vh ***
// Contract
// - on slot 0 never, 1..5 timeslots
// - on slot 6,7 follow hardware enables
// - on bit 8 opmode, resets normal
// - on voltage bits 4:0, reset 0.90V
// - codes 50mV then 100mV from 0Fh
// - sleep slot 1..5 disable slots 5..1
// - sleep 0,6,7 transition slots 5,3,1
// - hw enabled: 1..5 pick sleep slot
// - sleep bit 8 opmode, resets low power
// - sleep voltage bits 4:0, reset zero
// - hw control picks on or sleep voltage
`ifndef REGULATOR_FOUR_DEFINES_VH
`define REGULATOR_FOUR_DEFINES_VH
`define ON_CTRL_IDX 16'h4072
`define SLEEP_CTRL_IDX 16'h4073
`define HWCTRL_IDX 16'h4074
`define STATUS_IDX 16'h4075
`define SLOT_HI 15
`define SLOT_LO 13
`define OPMODE_BIT 8
`define VCODE_HI 4
`define VCODE_LO 0
`define FIELD_MASK 16'he11f
`define ON_RESET 16'h0000
`define SLEEP_RESET 16'h0100
`define BASE_MV 12'h384
`define STEP_LO_MV 12'h032
`define STEP_HI_MV 12'h064
`define KNEE_CODE 5'h0f
`define KNEE_MV 12'h6a4
`endif

// *** hdl/voltage_decode.v ***
`timescale 1ns/1ps
`default_nettype none
`include "regulator_four_defines.vh"
module voltage_decode (
    // code in
    input wire [4:0] code,
    // millivolts out
    output wire [11:0] millivolts
);
    function [11:0] to_mv;
        input [4:0] c;
        begin
            if (c < `KNEE_CODE) begin
                to_mv = `BASE_MV + c * `STEP_LO_MV;
            end else begin
                to_mv = `KNEE_MV + (c - `KNEE_CODE) * `STEP_HI_MV;
            end
        end
    endfunction
    assign millivolts = to_mv(code);
endmodule
`default_nettype wire

// *** hdl/slot_decode.v ***
`timescale 1ns/1ps
`default_nettype none
`include "regulator_four_defines.vh"
module slot_decode (
    // fields
    input wire [2:0] on_slot,
    input wire [2:0] sleep_slot,
    // decoded
    output reg [2:0] on_timeslot,
    output reg on_by_hw1,
    output reg on_by_hw2,
    output reg [2:0] sleep_timeslot,
    output reg sleep_disables
);
    always @* begin
        on_timeslot = 3'h0;
        on_by_hw1 = 1'b0;
        on_by_hw2 = 1'b0;
        case (on_slot)
            3'h6: on_by_hw1 = 1'b1;
            3'h7: on_by_hw2 = 1'b1;
            default: on_timeslot = on_slot;
        endcase
        sleep_disables = 1'b0;
        case (sleep_slot)
            3'h0: sleep_timeslot = 3'h5;
            3'h6: sleep_timeslot = 3'h3;
            3'h7: sleep_timeslot = 3'h1;
            default: begin
                // under hw enable the same codes only choose the slot
                sleep_timeslot = 3'h6 - sleep_slot;
                sleep_disables = ~(on_by_hw1 | on_by_hw2);
            end
        endcase
    end
endmodule
`default_nettype wire

// *** hdl/regulator_on_sleep_config.v ***
`timescale 1ns/1ps
`default_nettype none
`include "regulator_four_defines.vh"
module regulator_on_sleep_config (
    // clock and reset
    input wire clk_sys,
    input wire nrst,
    // avalon-mm slave, word index address
    input wire [15:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    // hardware enable pins
    input wire hw_enable1,
    input wire hw_enable2,
    // sequencer and analogue side
    input wire sleep_active,
    output reg [2:0] on_timeslot,
    output reg on_by_hw1,
    output reg on_by_hw2,
    output reg [2:0] sleep_timeslot,
    output reg sleep_disables,
    output reg hw_enable_level,
    output reg lp_mode,
    output reg [4:0] dac_code,
    output reg [11:0] dac_millivolts
);
    reg [15:0] on_q;
    reg [15:0] sleep_q;
    reg hwc_pick_q;
    reg hwc_active_q;
    reg ack_q;
    reg [1:0] hw1_sync_q;
    reg [1:0] hw2_sync_q;
    wire [2:0] on_ts_d;
    wire on_hw1_d;
    wire on_hw2_d;
    wire [2:0] sleep_ts_d;
    wire sleep_dis_d;
    wire [11:0] mv_d;
    reg [4:0] code_d;
    reg lp_d;
    wire access = avs_read | avs_write;
    wire wr = avs_write & ack_q;

    // one wait cycle per access keeps readdata registered
    assign avs_waitrequest = access & ~ack_q;

    function [15:0] merge;
        input [15:0] old;
        input [31:0] data;
        input [3:0] be;
        reg [15:0] m;
        begin
            m = {be[1] ? data[15:8] : old[15:8], be[0] ? data[7:0] : old[7:0]};
            merge = m & `FIELD_MASK;
        end
    endfunction

    always @(posedge clk_sys) begin
        if (!nrst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= access & ~ack_q;
        end
    end

    always @(posedge clk_sys) begin
        if (!nrst) begin
            on_q <= `ON_RESET;
            sleep_q <= `SLEEP_RESET;
            hwc_pick_q <= 1'b0;
            hwc_active_q <= 1'b0;
        end else if (wr) begin
            case (avs_address)
                `ON_CTRL_IDX: on_q <= merge(on_q, avs_writedata, avs_byteenable);
                `SLEEP_CTRL_IDX: sleep_q <= merge(sleep_q, avs_writedata, avs_byteenable);
                `HWCTRL_IDX: begin
                    if (avs_byteenable[0]) begin
                        hwc_pick_q <= avs_writedata[0];
                        hwc_active_q <= avs_writedata[1];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always @(posedge clk_sys) begin
        if (!nrst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read & ~ack_q) begin
            case (avs_address)
                `ON_CTRL_IDX: avs_readdata <= {16'h0000, on_q};
                `SLEEP_CTRL_IDX: avs_readdata <= {16'h0000, sleep_q};
                `HWCTRL_IDX: avs_readdata <= {30'h0, hwc_active_q, hwc_pick_q};
                `STATUS_IDX: avs_readdata <= {13'h0, hw_enable_level, lp_mode, dac_code, dac_millivolts};
                default: avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // pins come from outside the clock domain
    always @(posedge clk_sys) begin
        if (!nrst) begin
            hw1_sync_q <= 2'b00;
            hw2_sync_q <= 2'b00;
        end else begin
            hw1_sync_q <= {hw1_sync_q[0], hw_enable1};
            hw2_sync_q <= {hw2_sync_q[0], hw_enable2};
        end
    end

    slot_decode u_slot (
        .on_slot(on_q[`SLOT_HI:`SLOT_LO]),
        .sleep_slot(sleep_q[`SLOT_HI:`SLOT_LO]),
        .on_timeslot(on_ts_d),
        .on_by_hw1(on_hw1_d),
        .on_by_hw2(on_hw2_d),
        .sleep_timeslot(sleep_ts_d),
        .sleep_disables(sleep_dis_d)
    );

    always @* begin
        if (hwc_active_q) begin
            code_d = hwc_pick_q ? sleep_q[`VCODE_HI:`VCODE_LO] : on_q[`VCODE_HI:`VCODE_LO];
            lp_d = on_q[`OPMODE_BIT];
        end else if (sleep_active) begin
            code_d = sleep_q[`VCODE_HI:`VCODE_LO];
            lp_d = sleep_q[`OPMODE_BIT];
        end else begin
            code_d = on_q[`VCODE_HI:`VCODE_LO];
            lp_d = on_q[`OPMODE_BIT];
        end
    end

    voltage_decode u_volt (
        .code(code_d),
        .millivolts(mv_d)
    );

    always @(posedge clk_sys) begin
        if (!nrst) begin
            on_timeslot <= 3'h0;
            on_by_hw1 <= 1'b0;
            on_by_hw2 <= 1'b0;
            sleep_timeslot <= 3'h5;
            sleep_disables <= 1'b0;
            hw_enable_level <= 1'b0;
            lp_mode <= 1'b0;
            dac_code <= 5'h00;
            dac_millivolts <= `BASE_MV;
        end else begin
            on_timeslot <= on_ts_d;
            on_by_hw1 <= on_hw1_d;
            on_by_hw2 <= on_hw2_d;
            sleep_timeslot <= sleep_ts_d;
            sleep_disables <= sleep_dis_d;
            hw_enable_level <= (on_hw1_d & hw1_sync_q[1]) | (on_hw2_d & hw2_sync_q[1]);
            lp_mode <= lp_d;
            dac_code <= code_d;
            dac_millivolts <= mv_d;
        end
    end
endmodule
`default_nettype wire

// *** tb/reg_cfg_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module reg_cfg_monitor (
    // bus
    input wire clk_sys,
    input wire nrst,
    input wire [15:0] avs_address,
    input wire avs_read,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    // decoded
    input wire [2:0] on_timeslot,
    input wire on_by_hw1,
    input wire on_by_hw2,
    input wire [2:0] sleep_timeslot,
    input wire sleep_disables,
    input wire lp_mode,
    input wire [4:0] dac_code,
    input wire [11:0] dac_millivolts
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // a read is answered in the cycle its waitrequest drops
    wire rd_ok = avs_read && !avs_waitrequest;
    a_mv_low_step: assert property (dac_code < 5'h0f |-> dac_millivolts == 12'h384 + 12'h032 * dac_code)
        else $error("low mv");
    a_mv_high_step: assert property (dac_code >= 5'h0f |-> dac_millivolts == 12'h6a4 + 12'h064 * (dac_code - 5'h0f))
        else $error("high mv");
    a_on_slot_range: assert property (on_timeslot <= 3'h5)
        else $error("on slot");
    a_hw_one_pin: assert property (!(on_by_hw1 && on_by_hw2))
        else $error("two pins");
    a_hw_no_disable: assert property (on_by_hw1 || on_by_hw2 |-> !sleep_disables)
        else $error("hw disable");
    a_sleep_slot_range: assert property (sleep_timeslot != 3'h0 && sleep_timeslot <= 3'h5)
        else $error("sleep slot");
    a_reset_fields: assert property ($rose(nrst) |-> on_timeslot == 3'h0 && !lp_mode && dac_millivolts == 12'h384)
        else $error("reset out");
    a_unmapped_zero: assert property (rd_ok && (avs_address < 16'h4072 || avs_address > 16'h4075)
        |-> avs_readdata == 32'h0)
        else $error("unmapped");
    a_ctrl_mask: assert property (rd_ok && avs_address[15:1] == 15'h2039 |-> (avs_readdata & 32'hffff1ee0) == 32'h0)
        else $error("mask");
endmodule
`default_nettype wire

// *** tb/power_seq_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module power_seq_model (
    // from bench
    input wire clk_sys,
    input wire [2:0] cmd,
    // to block
    output reg sleep_active,
    output reg hw_enable1,
    output reg hw_enable2
);
    // pins step only on the clock, so they never glitch into the sync stages
    initial {sleep_active, hw_enable1, hw_enable2} = 3'h0;
    always @(posedge clk_sys) begin
        {sleep_active, hw_enable1, hw_enable2} <= cmd;
    end
endmodule
`default_nettype wire

// *** tb/regulator_on_sleep_config_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module regulator_on_sleep_config_tb;
    reg clk_sys = 0, nrst = 0, rd = 0, wr = 0;
    reg [15:0] adr = 0;
    reg [31:0] wd = 0, on_v, sl_v, q;
    reg [2:0] cmd = 0;
    reg [3:0] be = 4'hf;
    reg hx;
    reg [4:0] vc;
    wire [31:0] rdata;
    wire wt, sa, h1, h2, hw1, hw2, sd, hl, lp;
    wire [2:0] ot, st;
    wire [4:0] dc;
    wire [11:0] mv;
    integer fails = 0, checks = 0, i, j, m;
    always #5 clk_sys = ~clk_sys;
    power_seq_model psm (.clk_sys(clk_sys), .cmd(cmd), .sleep_active(sa), .hw_enable1(h1), .hw_enable2(h2));
    regulator_on_sleep_config uut (.clk_sys(clk_sys), .nrst(nrst), .avs_address(adr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wt),
        .hw_enable1(h1), .hw_enable2(h2), .sleep_active(sa), .on_timeslot(ot), .on_by_hw1(hw1),
        .on_by_hw2(hw2), .sleep_timeslot(st), .sleep_disables(sd), .hw_enable_level(hl), .lp_mode(lp),
        .dac_code(dc), .dac_millivolts(mv));
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("mismatch %0t seen %h exp %h", $time, seen, exp);
            end
        end
    endtask
    // waitrequest and readdata are taken at the rising edge, before the flops move
    task bus(input w, input [15:0] a, input [31:0] d);
        begin
            @(posedge clk_sys);
            rd <= !w;
            wr <= w;
            adr <= a;
            wd <= d;
            @(posedge clk_sys);
            while (wt !== 1'b0) @(posedge clk_sys);
            q = rdata;
            rd <= 0;
            wr <= 0;
        end
    endtask
    task stop_test;
        begin
            if (fails == 0 && checks > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    initial begin
        q = $urandom(61197);
        repeat (16) @(posedge clk_sys);
        nrst <= 1;
        bus(0, 16'h4072, 0); chk(q, 32'h0);
        bus(0, 16'h4073, 0); chk(q, 32'h100);
        bus(0, 16'h4071, 0); chk(q, 32'h0);
        for (i = 0; i < 8; i = i + 1) for (j = 0; j < 8; j = j + 1) begin
            on_v = $urandom;
            sl_v = $urandom;
            on_v[15:13] = i[2:0];
            sl_v[15:13] = j[2:0];
            cmd <= sl_v[18:16];
            bus(1, 16'h4072, on_v);
            bus(1, 16'h4073, sl_v);
            bus(1, 16'h4074, 2 + j % 2);
            bus(0, 16'h4072, 0); chk(q, on_v & 32'he11f);
            bus(0, 16'h4073, 0); chk(q, sl_v & 32'he11f);
            bus(0, 16'h4074, 0); chk(q, 2 + j % 2);
            repeat (3) @(posedge clk_sys);
            @(negedge clk_sys);
            vc = j % 2 ? sl_v[4:0] : on_v[4:0];
            m = vc < 15 ? 900 + 50 * vc : 100 * vc + 200;
            hx = i == 6 ? h1 : i == 7 ? h2 : 1'b0;
            chk(ot, (i > 0 && i < 6) ? i : 0);
            chk({hw1, hw2}, {i == 6, i == 7});
            chk(st, j == 0 ? 5 : j == 6 ? 3 : j == 7 ? 1 : 6 - j);
            chk(sd, j > 0 && j < 6 && i < 6);
            chk(dc, vc);
            chk(mv, m);
            chk(lp, on_v[8]);
            chk(hl, hx);
            bus(0, 16'h4075, 0); chk(q, {13'h0, hx, on_v[8], vc, m[11:0]});
            // hardware control off: the sequencer's sleep level picks the field
            bus(1, 16'h4074, 0);
            repeat (3) @(posedge clk_sys);
            @(negedge clk_sys);
            chk(dc, cmd[2] ? sl_v[4:0] : on_v[4:0]);
            chk(lp, cmd[2] ? sl_v[8] : on_v[8]);
        end
        be <= 4'h1;
        bus(1, 16'h4072, 32'hffff_ffff);
        be <= 4'hf;
        bus(0, 16'h4072, 0); chk(q, {on_v[15:8], 8'hff} & 32'he11f);
        @(posedge clk_sys);
        nrst <= 0;
        repeat (2) @(posedge clk_sys);
        nrst <= 1;
        bus(0, 16'h4072, 0); chk(q, 32'h0);
        bus(0, 16'h4073, 0); chk(q, 32'h100);
        stop_test;
    end
    initial begin
        #200000;
        fails = fails + 1;
        stop_test;
    end
endmodule
bind regulator_on_sleep_config reg_cfg_monitor mon (.clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .on_timeslot(on_timeslot), .on_by_hw1(on_by_hw1), .on_by_hw2(on_by_hw2), .sleep_timeslot(sleep_timeslot),
    .sleep_disables(sleep_disables), .lp_mode(lp_mode), .dac_code(dac_code), .dac_millivolts(dac_millivolts));
`default_nettype wire
